// *** shared/sec_defines.svh ***
// Constants of the scratchpad EEPROM command engine.
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH

`define SEC_CMD_WRITE_SP 8'h0F
`define SEC_CMD_READ_SP  8'hAA
`define SEC_CMD_COPY_SP  8'h55
`define SEC_CMD_READ_MEM 8'hF0
`define SEC_LOCK_WP      8'h55
`define SEC_LOCK_EP      8'hAA
`define SEC_ONES         8'hFF
`define SEC_ZERO_BYTE    8'h00
`define SEC_MEM_LAST     16'h008F
`define SEC_MEM_BYTES    144
`define SEC_REG_ROW      8'h80
`define SEC_COPY_BYTE    8'h84
`define SEC_FACT_BYTE    8'h85
`define SEC_USER_LAST    8'h87
`define SEC_ADDR_PROT0   8'h80
`define SEC_ADDR_PROT1   8'h81
`define SEC_ADDR_PROT2   8'h82
`define SEC_ADDR_PROT3   8'h83
`define SEC_ROW_LAST     3'h7
`define SEC_ROW_FIRST    3'h0
`define SEC_BIT_LAST     3'h7
`define SEC_PRE_BYTES    4'h3
`define SEC_IDX_MAX      4'hF
`define SEC_CRC_POLY     16'hA001
`define SEC_CRC_CLEAR    16'h0000
`define SEC_PROG_TIME_US 5000
`define SEC_CLK_MHZ      250
`define SEC_PROG_WRITES  32'h0000_0008

`endif

// *** shared/sec_pkg.sv ***
// Types and the CRC-16 step shared by the command engine files.
`include "sec_defines.svh"
package sec_pkg;

  typedef enum logic [3:0] {
    SEC_IDLE  = 4'h0,
    SEC_CMD   = 4'h1,
    SEC_ADDR0 = 4'h3,
    SEC_ADDR1 = 4'h2,
    SEC_WDATA = 4'h6,
    SEC_WCRC  = 4'h7,
    SEC_DONE  = 4'h5,
    SEC_TXS   = 4'h4,
    SEC_AUTH  = 4'hC,
    SEC_PROG  = 4'hD,
    SEC_ALT   = 4'hF,
    SEC_FFS   = 4'hE,
    SEC_MRD   = 4'hA
  } sec_state_t;

  function automatic logic [15:0] sec_crc_step(input logic [15:0] c,
                                               input logic        b);
    sec_crc_step = (c >> 1) ^ ((c[0] ^ b) ? `SEC_CRC_POLY : `SEC_CRC_CLEAR);
  endfunction

endpackage

// *** design/sec_crc16.sv ***
// Bit-serial CRC-16 generator with clear and shift controls.
`timescale 1ns/1ps
`include "sec_defines.svh"
module sec_crc16 (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        crc_clr,
  input  wire logic        crc_shift,
  input  wire logic        crc_bit,
  output logic      [15:0] crc
);

  logic [15:0] next_crc;

  always_comb
  begin
    next_crc = crc;
    if (crc_clr)
      next_crc = `SEC_CRC_CLEAR;
    else if (crc_shift)
      next_crc = sec_pkg::sec_crc_step(crc, crc_bit);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      crc <= `SEC_CRC_CLEAR;
    else
      crc <= next_crc;
  end

endmodule

// *** design/sec_mem.sv ***
// EEPROM array with one read port, one write port and protection bytes.
`timescale 1ns/1ps
`include "sec_defines.svh"
module sec_mem (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] rd_addr,
  output logic      [7:0]  rd_data,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  prot_page0,
  output logic      [7:0]  prot_page1,
  output logic      [7:0]  prot_page2,
  output logic      [7:0]  prot_page3,
  output logic      [7:0]  prot_copy,
  output logic      [7:0]  prot_factory
);

  logic [7:0] cells [0:`SEC_MEM_BYTES-1];

  // Reads outside the array return ones.
  assign rd_data = (rd_addr <= `SEC_MEM_LAST) ? cells[rd_addr[7:0]]
                                              : `SEC_ONES;
  assign prot_page0   = cells[`SEC_ADDR_PROT0];
  assign prot_page1   = cells[`SEC_ADDR_PROT1];
  assign prot_page2   = cells[`SEC_ADDR_PROT2];
  assign prot_page3   = cells[`SEC_ADDR_PROT3];
  assign prot_copy    = cells[`SEC_COPY_BYTE];
  assign prot_factory = cells[`SEC_FACT_BYTE];

  // Reset leaves every cell in the erased state.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < `SEC_MEM_BYTES; i++)
        cells[i] <= `SEC_ONES;
    end
    else if (wr_en && ({8'h00, wr_addr} <= `SEC_MEM_LAST))
      cells[wr_addr] <= wr_data;
  end

endmodule

// *** design/sec_engine.sv ***
// Memory command engine: scratchpad write, read, copy and memory read.
`timescale 1ns/1ps
`include "sec_defines.svh"
module sec_engine #(
  parameter int unsigned PROG_CYCLES = `SEC_PROG_TIME_US * `SEC_CLK_MHZ
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic bus_reset,
  input  wire logic rom_ok,
  input  wire logic slot_valid,
  input  wire logic slot_wbit,
  input  wire logic power_fail,
  input  wire logic od_set,
  input  wire logic od_clear,
  output logic      tx_bit,
  output logic      overdrive_flag,
  output logic      copy_busy
);

  // ********************************************************************
  // Declarations.
  // ********************************************************************
  sec_pkg::sec_state_t state, next_state;
  logic [2:0]  bcnt, next_bcnt;
  logic [7:0]  sh, next_sh;
  logic [7:0]  cmd, next_cmd;
  logic [15:0] ta, next_ta;
  logic [2:0]  e, next_e;
  logic        pf, next_pf;
  logic        aa, next_aa;
  logic [7:0]  sp [0:7];
  logic [7:0]  next_sp [0:7];
  logic [3:0]  idx, next_idx;
  logic        wfirst, next_wfirst;
  logic        auth_ok, next_auth_ok;
  logic [15:0] rdp, next_rdp;
  logic        alt, next_alt;
  logic [31:0] prog, next_prog;
  logic        next_tx, next_od, od_q, txq;
  logic [15:0] crc, crc_fin;
  logic        crc_clr, crc_shift, crc_bit;
  logic [7:0]  rx_byte, es_byte, mem_rd, loaded, rsp_byte, expect_b;
  logic [7:0]  p0, p1, p2, p3, pcopy, pfact, pcode;
  logic [15:0] rd_addr;
  logic [2:0]  off, sp_end, sel_off;
  logic [3:0]  sel;
  logic        byte_end, wp, ep, addr_ok, cprot, mem_wr;

  function automatic logic locked(input logic [7:0] code);
    locked = (code == `SEC_LOCK_WP) || (code == `SEC_LOCK_EP);
  endfunction

  // ********************************************************************
  // Submodules.
  // ********************************************************************
  sec_crc16 u_crc (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .crc_clr   (crc_clr),
    .crc_shift (crc_shift),
    .crc_bit   (crc_bit),
    .crc       (crc)
  );

  sec_mem u_mem (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .rd_addr      (rd_addr),
    .rd_data      (mem_rd),
    .wr_en        (mem_wr),
    .wr_addr      ({ta[7:3], prog[2:0]}),
    .wr_data      (sp[prog[2:0]]),
    .prot_page0   (p0),
    .prot_page1   (p1),
    .prot_page2   (p2),
    .prot_page3   (p3),
    .prot_copy    (pcopy),
    .prot_factory (pfact)
  );

  // ********************************************************************
  // Decoding shared by the commands.
  // ********************************************************************
  assign rx_byte  = {slot_wbit, sh[7:1]};
  assign byte_end = slot_valid && (bcnt == `SEC_BIT_LAST);
  assign es_byte  = {aa, 1'b0, pf, 2'b00, e};
  assign sp_end   = e - ta[2:0];
  assign off      = wfirst ? ta[2:0] : e + 3'h1;
  assign sel      = idx + 4'h1;
  assign sel_off  = ta[2:0] + sel[2:0] - 3'h3;
  assign copy_busy      = (state == sec_pkg::SEC_PROG);
  assign tx_bit         = txq;
  assign overdrive_flag = od_q;

  always_comb
  begin
    rd_addr = rdp;
    if (state == sec_pkg::SEC_ADDR1)
      rd_addr = {rx_byte, rdp[7:0]};
    else if (state == sec_pkg::SEC_WDATA)
      rd_addr = {ta[15:3], off};
  end

  // Protection of the byte being loaded into the scratchpad.
  always_comb
  begin
    case (ta[6:5])
      2'h0:    pcode = p0;
      2'h1:    pcode = p1;
      2'h2:    pcode = p2;
      default: pcode = p3;
    endcase
    wp = 1'b0;
    ep = 1'b0;
    if (ta[15:8] != `SEC_ZERO_BYTE)
      wp = 1'b1;
    else if (ta[7:0] < `SEC_REG_ROW)
    begin
      wp = (pcode == `SEC_LOCK_WP);
      ep = (pcode == `SEC_LOCK_EP);
    end
    else if (rd_addr[7:0] <= `SEC_COPY_BYTE)
      wp = locked(mem_rd);
    else if (rd_addr[7:0] == `SEC_FACT_BYTE)
      wp = locked(pfact);
    else if (rd_addr[7:0] <= `SEC_USER_LAST)
      wp = (pfact == `SEC_LOCK_EP);
    else
      wp = 1'b1;
    loaded = rx_byte;
    if (wp)
      loaded = mem_rd;
    else if (ep)
      loaded = rx_byte & mem_rd;
  end

  // Copy is allowed only to aligned, existing, unprotected rows.
  always_comb
  begin
    addr_ok = (ta[15:8] == `SEC_ZERO_BYTE) && (ta[7:0] <= `SEC_USER_LAST)
              && (ta[2:0] == `SEC_ROW_FIRST);
    cprot   = locked(pcopy) && ((ta[7:0] >= `SEC_REG_ROW)
              || (pcode == `SEC_LOCK_WP));
    case (idx[1:0])
      2'h0:    expect_b = ta[7:0];
      2'h1:    expect_b = ta[15:8];
      default: expect_b = es_byte;
    endcase
  end

  // Byte stream of the scratchpad read.
  always_comb
  begin
    crc_fin = sec_pkg::sec_crc_step(crc, crc_bit);
    if (sel == 4'h1)
      rsp_byte = ta[15:8];
    else if (sel == 4'h2)
      rsp_byte = es_byte;
    else if (sel <= `SEC_PRE_BYTES + {1'b0, sp_end})
      rsp_byte = sp[sel_off];
    else if (sel == `SEC_PRE_BYTES + {1'b0, sp_end} + 4'h1)
      rsp_byte = ~crc_fin[7:0];
    else if (sel == `SEC_PRE_BYTES + {1'b0, sp_end} + 4'h2)
      rsp_byte = ~crc[15:8];
    else
      rsp_byte = `SEC_ONES;
  end

  // ********************************************************************
  // Command sequencer.
  // ********************************************************************
  always_comb
  begin
    next_state   = state;
    next_bcnt    = bcnt;
    next_sh      = sh;
    next_cmd     = cmd;
    next_ta      = ta;
    next_e       = e;
    next_pf      = pf;
    next_aa      = aa;
    next_sp      = sp;
    next_idx     = idx;
    next_wfirst  = wfirst;
    next_auth_ok = auth_ok;
    next_rdp     = rdp;
    next_alt     = alt;
    next_prog    = prog;
    mem_wr       = 1'b0;
    crc_clr      = 1'b0;
    crc_bit      = slot_wbit;
    crc_shift    = 1'b0;
    if (slot_valid)
    begin
      next_bcnt = bcnt + 3'h1;
      next_sh   = rx_byte;
    end
    case (state)
      sec_pkg::SEC_IDLE:
      begin
        next_bcnt = 3'h0;
        if (rom_ok)
        begin
          next_state = sec_pkg::SEC_CMD;
          crc_clr    = 1'b1;
        end
      end
      sec_pkg::SEC_CMD:
      begin
        crc_shift = slot_valid;
        if (byte_end)
        begin
          next_cmd = rx_byte;
          next_idx = 4'h0;
          if (rx_byte == `SEC_CMD_WRITE_SP || rx_byte == `SEC_CMD_READ_MEM)
            next_state = sec_pkg::SEC_ADDR0;
          else if (rx_byte == `SEC_CMD_READ_SP)
          begin
            next_state = sec_pkg::SEC_TXS;
            next_sh    = ta[7:0];
          end
          else if (rx_byte == `SEC_CMD_COPY_SP)
          begin
            next_state   = sec_pkg::SEC_AUTH;
            next_auth_ok = 1'b1;
          end
          else
            next_state = sec_pkg::SEC_DONE;
        end
      end
      sec_pkg::SEC_ADDR0:
      begin
        crc_shift = slot_valid;
        if (byte_end)
        begin
          next_state = sec_pkg::SEC_ADDR1;
          if (cmd == `SEC_CMD_WRITE_SP)
            next_ta[7:0] = rx_byte;
          else
            next_rdp[7:0] = rx_byte;
        end
      end
      sec_pkg::SEC_ADDR1:
      begin
        crc_shift = slot_valid;
        if (byte_end && cmd == `SEC_CMD_WRITE_SP)
        begin
          next_state    = sec_pkg::SEC_WDATA;
          next_ta[15:8] = rx_byte;
          next_e        = ta[2:0];
          next_pf       = 1'b1;
          next_wfirst   = 1'b1;
        end
        else if (byte_end)
        begin
          next_state = sec_pkg::SEC_MRD;
          next_sh    = mem_rd;
          next_rdp   = rd_addr + 16'h0001;
        end
      end
      sec_pkg::SEC_WDATA:
      begin
        crc_shift = slot_valid;
        if (byte_end)
        begin
          next_sp[off] = loaded;
          next_e       = off;
          next_aa      = 1'b0;
          next_wfirst  = 1'b0;
          if (off == `SEC_ROW_LAST)
          begin
            next_pf    = 1'b0;
            next_state = sec_pkg::SEC_WCRC;
            next_sh    = ~crc_fin[7:0];
          end
        end
      end
      sec_pkg::SEC_WCRC:
      begin
        if (slot_valid)
          next_sh = {1'b1, sh[7:1]};
        if (byte_end && idx == 4'h0)
        begin
          next_idx = 4'h1;
          next_sh  = ~crc[15:8];
        end
        else if (byte_end)
          next_state = sec_pkg::SEC_DONE;
      end
      sec_pkg::SEC_TXS:
      begin
        crc_bit   = sh[0];
        crc_shift = slot_valid
                    && (idx <= `SEC_PRE_BYTES + {1'b0, sp_end});
        if (slot_valid)
          next_sh = {1'b1, sh[7:1]};
        if (byte_end)
        begin
          next_sh = rsp_byte;
          if (idx != `SEC_IDX_MAX)
            next_idx = sel;
        end
      end
      sec_pkg::SEC_AUTH:
      begin
        if (byte_end)
        begin
          next_auth_ok = auth_ok && (rx_byte == expect_b);
          next_idx     = sel;
          if (idx == 4'h2)
          begin
            if (next_auth_ok && addr_ok && !pf && !cprot)
            begin
              next_aa    = 1'b1;
              next_state = sec_pkg::SEC_PROG;
              next_prog  = 32'h0;
            end
            else
              next_state = sec_pkg::SEC_DONE;
          end
        end
      end
      sec_pkg::SEC_PROG:
      begin
        mem_wr    = (prog < `SEC_PROG_WRITES);
        next_prog = prog + 32'h1;
        if (power_fail)
          next_state = sec_pkg::SEC_FFS;
        else if (prog >= PROG_CYCLES - 32'h1)
        begin
          next_state = sec_pkg::SEC_ALT;
          next_alt   = 1'b0;
        end
      end
      sec_pkg::SEC_ALT:
      begin
        if (slot_valid)
          next_alt = ~alt;
      end
      sec_pkg::SEC_MRD:
      begin
        if (slot_valid)
          next_sh = {1'b1, sh[7:1]};
        if (byte_end)
        begin
          next_sh = mem_rd;
          if (rdp <= `SEC_MEM_LAST)
            next_rdp = rdp + 16'h0001;
        end
      end
      default:
        next_bcnt = 3'h0;
    endcase
    if (power_fail)
      next_pf = 1'b1;
    if (bus_reset)
      next_state = sec_pkg::SEC_IDLE;
    case (next_state)
      sec_pkg::SEC_TXS, sec_pkg::SEC_WCRC, sec_pkg::SEC_MRD:
        next_tx = next_sh[0];
      sec_pkg::SEC_ALT:
        next_tx = next_alt;
      default:
        next_tx = 1'b1;
    endcase
    next_od = od_clear ? 1'b0 : (od_set ? 1'b1 : od_q);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state   <= sec_pkg::SEC_IDLE;
      bcnt    <= 3'h0;
      sh      <= `SEC_ONES;
      cmd     <= `SEC_ZERO_BYTE;
      ta      <= 16'h0000;
      e       <= 3'h0;
      pf      <= 1'b1;
      aa      <= 1'b0;
      sp      <= '{default: `SEC_ONES};
      idx     <= 4'h0;
      wfirst  <= 1'b0;
      auth_ok <= 1'b0;
      rdp     <= 16'h0000;
      alt     <= 1'b0;
      prog    <= 32'h0;
      txq     <= 1'b1;
      od_q    <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      bcnt    <= next_bcnt;
      sh      <= next_sh;
      cmd     <= next_cmd;
      ta      <= next_ta;
      e       <= next_e;
      pf      <= next_pf;
      aa      <= next_aa;
      sp      <= next_sp;
      idx     <= next_idx;
      wfirst  <= next_wfirst;
      auth_ok <= next_auth_ok;
      rdp     <= next_rdp;
      alt     <= next_alt;
      prog    <= next_prog;
      txq     <= next_tx;
      od_q    <= next_od;
    end
  end

endmodule

// *** bench/sec_engine_props.sv ***
// Port checks for the command engine.
`timescale 1ns/1ps
module sec_engine_props #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_reset,
  input wire logic rom_ok,
  input wire logic slot_valid,
  input wire logic slot_wbit,
  input wire logic power_fail,
  input wire logic od_set,
  input wire logic od_clear,
  input wire logic tx_bit,
  input wire logic overdrive_flag,
  input wire logic copy_busy
);
  // ****************************************
  // Helper state and assertions.
  // ****************************************
  logic [31:0] busy_cnt;
  logic        unclean;
  logic        idle;
  logic        ff_mode;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk)
  begin
    busy_cnt <= (copy_busy && !sys_rst) ? busy_cnt + 32'h1 : 32'h0;
    unclean  <= (sys_rst || power_fail) ? 1'b1 :
                ($rose(copy_busy) ? 1'b0 : unclean);
    idle     <= (sys_rst || bus_reset) ? 1'b1 : (rom_ok ? 1'b0 : idle);
    ff_mode  <= (sys_rst || bus_reset) ? 1'b0 :
                ((power_fail && copy_busy) ? 1'b1 : ff_mode);
  end
  a_reset_values: assert property (disable iff (1'b0)
    sys_rst |=> tx_bit && !overdrive_flag && !copy_busy)
    else $error("Outputs are not at their reset values.");
  a_od_set: assert property (
    od_set && !od_clear |=> overdrive_flag)
    else $error("Overdrive flag did not set.");
  a_od_clear: assert property (
    od_clear |=> !overdrive_flag)
    else $error("Overdrive flag did not clear.");
  a_od_hold: assert property (
    !od_set && !od_clear |=> $stable(overdrive_flag))
    else $error("Overdrive flag changed on its own.");
  a_busy_length: assert property (
    $fell(copy_busy) && !unclean |-> busy_cnt == PROG_CYCLES)
    else $error("Programming time is wrong.");
  a_busy_start: assert property (
    $rose(copy_busy) |-> $past(slot_valid) || $past(slot_valid, 2))
    else $error("Programming began without a slot.");
  a_busy_refuse: assert property (
    copy_busy && slot_valid && !power_fail |=>
      !copy_busy || $stable(tx_bit))
    else $error("Slot acted on during programming.");
  a_tx_stands: assert property (
    $changed(tx_bit) |-> $past(slot_valid) || $past(bus_reset) ||
      $past(copy_busy) || $past(power_fail))
    else $error("Output bit changed without a cause.");
  a_idle_high: assert property (
    idle |-> tx_bit)
    else $error("Output bit low while idle.");
  a_ffs_high: assert property (
    ff_mode && !copy_busy |-> tx_bit)
    else $error("Disturbed copy did not return ones.");
endmodule

bind sec_engine sec_engine_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk(clk), .sys_rst(sys_rst), .bus_reset(bus_reset), .rom_ok(rom_ok),
  .slot_valid(slot_valid), .slot_wbit(slot_wbit), .power_fail(power_fail),
  .od_set(od_set), .od_clear(od_clear), .tx_bit(tx_bit),
  .overdrive_flag(overdrive_flag), .copy_busy(copy_busy));

// *** bench/sec_master.sv ***
// Bus master model that drives slots into the command engine.
`timescale 1ns/1ps
module sec_master (
  input  wire logic clk,
  input  wire logic tx_bit,
  output logic      bus_reset,
  output logic      rom_ok,
  output logic      slot_valid,
  output logic      slot_wbit
);
  // ****************************************
  // Start, slot and byte tasks.
  // ****************************************
  initial
  begin
    bus_reset  = 1'b0;
    rom_ok     = 1'b0;
    slot_valid = 1'b0;
    slot_wbit  = 1'b1;
  end
  task automatic start();
    @(negedge clk);
    bus_reset = 1'b1;
    @(negedge clk);
    bus_reset = 1'b0;
    rom_ok    = 1'b1;
    @(negedge clk);
    rom_ok    = 1'b0;
  endtask
  task automatic slot(input logic b, output logic r);
    @(negedge clk);
    r          = tx_bit;
    slot_valid = 1'b1;
    slot_wbit  = b;
    @(negedge clk);
    slot_valid = 1'b0;
    slot_wbit  = 1'b1;
  endtask
  task automatic put_byte(input logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++)
      slot(v[i], r);
  endtask
  task automatic get_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++)
      slot(1'b1, v[i]);
  endtask
endmodule

// *** bench/scratchpad_eeprom_command_engine_bench.sv ***
// Self-checking bench for the scratchpad command engine.
`timescale 1ns/1ps
module scratchpad_eeprom_command_engine_bench;
  // ****************************************
  // Signals, tasks and test sequence.
  // ****************************************
  logic        clk;
  logic        sys_rst;
  logic        power_fail;
  logic        od_set;
  logic        od_clear;
  logic        bus_reset;
  logic        rom_ok;
  logic        slot_valid;
  logic        slot_wbit;
  logic        tx_bit;
  logic        overdrive_flag;
  logic        copy_busy;
  int          miscompares;
  int          num_checks;
  logic [7:0]  w [8];
  logic [7:0]  e [8];
  logic [7:0]  d [8];
  logic [15:0] crc;

  sec_engine #(.PROG_CYCLES(20)) dut (
    .clk(clk), .sys_rst(sys_rst), .bus_reset(bus_reset), .rom_ok(rom_ok),
    .slot_valid(slot_valid), .slot_wbit(slot_wbit),
    .power_fail(power_fail), .od_set(od_set), .od_clear(od_clear),
    .tx_bit(tx_bit), .overdrive_flag(overdrive_flag),
    .copy_busy(copy_busy));
  sec_master u_master (
    .clk(clk), .tx_bit(tx_bit), .bus_reset(bus_reset), .rom_ok(rom_ok),
    .slot_valid(slot_valid), .slot_wbit(slot_wbit));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc_add(input logic [15:0] c,
                                          input logic [7:0]  v);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ v[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction
  task automatic send(input logic [7:0] v);
    u_master.put_byte(v);
    crc = crc_add(crc, v);
  endtask
  task automatic take(input logic [7:0] ex);
    logic [7:0] g;
    u_master.get_byte(g);
    check(16'(g), 16'(ex));
    crc = crc_add(crc, ex);
  endtask
  task automatic take_crc();
    logic [15:0] c;
    c = ~crc;
    take(c[7:0]);
    take(c[15:8]);
  endtask
  task automatic write_sp(input logic [15:0] a, input int n);
    u_master.start();
    crc = 16'h0000;
    send(8'h0F);
    send(a[7:0]);
    send(a[15:8]);
    for (int i = 0; i < n; i++)
      send(w[i]);
  endtask
  task automatic read_sp(input logic [15:0] a, input logic [7:0] es,
                         input int n);
    u_master.start();
    crc = 16'h0000;
    send(8'hAA);
    take(a[7:0]);
    take(a[15:8]);
    take(es);
    for (int i = 0; i < n; i++)
      take(e[i]);
    take_crc();
    take(8'hFF);
  endtask
  task automatic copy_sp(input logic [15:0] a, input logic [7:0] es,
                         input int mode);
    int   i;
    logic b;
    u_master.start();
    send(8'h55);
    send(a[7:0]);
    send(a[15:8]);
    send(es);
    for (i = 0; i < 4 && copy_busy !== 1'b1; i++)
      @(negedge clk);
    check(16'(copy_busy), 16'(mode != 0));
    u_master.slot(1'b1, b);
    if (mode == 2)
    begin
      @(negedge clk);
      power_fail = 1'b1;
      @(negedge clk);
      power_fail = 1'b0;
    end
    for (i = 0; i < 40 && copy_busy === 1'b1; i++)
      @(negedge clk);
    if (i == 40)
    begin
      miscompares++;
      report_and_stop();
    end
    take(mode == 1 ? 8'hAA : 8'hFF);
    take(mode == 1 ? 8'hAA : 8'hFF);
  endtask
  task automatic mem_rd(input logic [15:0] a);
    u_master.start();
    send(8'hF0);
    send(a[7:0]);
    send(a[15:8]);
  endtask

  initial
  begin
    repeat (100000) @(negedge clk);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    sys_rst = 1'b1;
    power_fail = 1'b0;
    od_set = 1'b0;
    od_clear = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (16) @(negedge clk);
    check(16'(tx_bit), 16'h0001);
    check(16'(overdrive_flag), 16'h0000);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      d[i] = 8'h5A + 8'(i) * 8'h23;
      w[i] = d[i];
      e[i] = d[i];
    end
    write_sp(16'h0020, 8);
    take_crc();
    take(8'hFF);
    $display("Test write scratchpad finished");
    read_sp(16'h0020, 8'h07, 8);
    copy_sp(16'h0020, 8'h07, 1);
    mem_rd(16'h0020);
    for (int i = 0; i < 8; i++)
      take(d[i]);
    mem_rd(16'h008F);
    take(8'hFF);
    take(8'hFF);
    read_sp(16'h0020, 8'h87, 8);
    $display("Test copy and memory read finished");
    w[0] = 8'h3C;
    w[1] = 8'hC3;
    e[0] = w[0];
    e[1] = w[1];
    write_sp(16'h0013, 2);
    read_sp(16'h0013, 8'h24, 2);
    copy_sp(16'h0013, 8'h24, 0);
    $display("Test partial write finished");
    for (int i = 0; i < 8; i++)
      w[i] = 8'hFF;
    w[0] = 8'h55;
    w[1] = 8'hAA;
    write_sp(16'h0080, 8);
    copy_sp(16'h0080, 8'h07, 1);
    for (int i = 0; i < 8; i++)
    begin
      w[i] = 8'hF0 ^ 8'(i);
      e[i] = w[i] & d[i];
    end
    write_sp(16'h0020, 8);
    read_sp(16'h0020, 8'h07, 8);
    for (int i = 0; i < 8; i++)
      e[i] = 8'hFF;
    write_sp(16'h0000, 8);
    read_sp(16'h0000, 8'h07, 8);
    $display("Test page protection finished");
    write_sp(16'h0040, 8);
    copy_sp(16'h0040, 8'h07, 2);
    for (int i = 0; i < 8; i++)
      e[i] = w[i];
    read_sp(16'h0040, 8'hA7, 8);
    $display("Test disturbed copy finished");
    for (int i = 0; i < 8; i++)
      w[i] = 8'h55;
    write_sp(16'h0080, 8);
    copy_sp(16'h0080, 8'h07, 1);
    write_sp(16'h0080, 8);
    copy_sp(16'h0080, 8'h07, 0);
    u_master.start();
    send(8'hCC);
    take(8'hFF);
    $display("Test copy protection finished");
    @(negedge clk);
    od_set = 1'b1;
    @(negedge clk);
    od_set = 1'b0;
    check(16'(overdrive_flag), 16'h0001);
    od_clear = 1'b1;
    @(negedge clk);
    od_clear = 1'b0;
    check(16'(overdrive_flag), 16'h0000);
    $display("Test overdrive flag finished");
    report_and_stop();
  end
endmodule
